// File: design/afae_cfg.svh
// Purpose: Constants for the access fault and address error exception unit.
// Assumes: Included by bare name from the design files.
// Notes:   Offsets are byte addresses on the plain register port.
`ifndef AFAE_CFG_SVH
`define AFAE_CFG_SVH

`define AFAE_VEC_ACCESS     8'h02
`define AFAE_VEC_ADDR_ERR   8'h03
`define AFAE_VEC_SCALE      2
`define AFAE_PST_RUN        4'h0
`define AFAE_PST_EXC        4'hC
`define AFAE_PST_HALT       4'h5
`define AFAE_SW_TRACE_HIGH  15
`define AFAE_SW_TRACE_LOW   14
`define AFAE_SW_SUPER       13
`define AFAE_OFF_VBP        8'h00
`define AFAE_OFF_STATUS     8'h04
`define AFAE_OFF_FRAME_PC   8'h08
`define AFAE_OFF_FRAME_SW   8'h0C
`define AFAE_OFF_FRAME_ADDR 8'h10
`define AFAE_OFF_WB0        8'h14
`define AFAE_OFF_WB1        8'h18
`define AFAE_OFF_WB2        8'h1C
`define AFAE_RST_VBP        32'h0000_0000
`define AFAE_SYNC_STAGES    2

`endif

// File: design/afae_pkg.sv
// Purpose: Types shared by the exception unit files.
// Assumes: Constants live in afae_cfg.svh.
// Notes:   Sequencer states follow a Gray path from idle to vector fetch.
package afae_pkg;

  typedef enum logic [2:0] {
    AFAE_IDLE  = 3'h0,
    AFAE_DRAIN = 3'h1,
    AFAE_SAVE  = 3'h3,
    AFAE_STACK = 3'h2,
    AFAE_VECT  = 3'h6,
    AFAE_HALT  = 3'h4
  } afae_state_t;

  typedef enum logic [1:0] {
    AFAE_KIND_WRITE = 2'h0,
    AFAE_KIND_READ  = 2'h1,
    AFAE_KIND_LINE  = 2'h2,
    AFAE_KIND_FETCH = 2'h3
  } afae_kind_t;

  typedef enum logic [1:0] {
    AFAE_CAUSE_DATA  = 2'h0,
    AFAE_CAUSE_FETCH = 2'h1,
    AFAE_CAUSE_ADDR  = 2'h2
  } afae_cause_t;

endpackage

// File: design/afae_sync.sv
// Purpose: Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes: Synchronous active-low reset.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`include "afae_cfg.svh"
module afae_sync
#(
  parameter int STAGES = `AFAE_SYNC_STAGES
)
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [STAGES-1:0] chain;

  initial
  begin
    if (STAGES < 2)
    begin
      $error("afae_sync needs at least two stages");
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      chain <= '0;
    end
    else
    begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];
endmodule

// File: design/afae_unit.sv
// Purpose: Detects, defers, prioritises and sequences access fault and address error exceptions.
// Assumes: Core-side inputs are on mclk; transfer_error_ack arrives from a pin.
// Notes:   Overview of operation follows.
// Overview of operation
// [RQ1] External logic aborts a bus cycle by asserting transfer error acknowledge.
// [RQ2] A bus error on a data write always starts exception processing.
// [RQ3] Bus errors on single reads or first line beat start processing.
// [RQ4] Later line beat errors abort; fault only if that long word is needed.
// [RQ5] Prefetch errors wait until used; change of flow discards them.
// [RQ6] External and internal faults share handling; a frame bit tells them apart.
// [RQ7] Data faults freeze pipeline, cancel instruction fetches, keep pending writes.
// [RQ8] Translation faults on write protected, supervisor only or nonresident pages.
// [RQ9] Translation miss searches tables; retry faults only on invalid descriptor or error.
// [RQ10] All stages idle first, then only the highest priority exception is taken.
// [RQ11] Faults wait for earlier instructions; their exception drops the pending fault.
// [RQ12] A dropped prefetch is reissued and faults again if still bad.
// [RQ13] Data faults wait for an in-progress prefetch cycle to finish.
// [RQ14] Save state word, enter supervisor, clear both trace bits, vector 2.
// [RQ15] Frame holds offset, logical PC, saved state word, fault address, write-backs.
// [RQ16] Up to three pending write-backs are recorded for software to finish.
// [RQ17] Fault during exception processing or state reload halts with status 5.
// [RQ18] Halted device leaves memory alone until external reset.
// [RQ19] Odd prefetch address raises address error without any bus cycle.
// [RQ20] Address error waits for executing instructions and defers to their exception.
// [RQ21] Address error follows the same sequence with vector 3.
// [RQ22] Address error frame holds instruction address and target with low bit cleared.
// [RQ23] Vector offset is the vector number times four.
// [RQ24] Handler address is read at vector base plus offset, supervisor data access.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "afae_cfg.svh"
module afae_unit
#(
  parameter int AW = 32,
  parameter int DW = 32
)
(
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  input  wire logic          transfer_error_ack,
  input  wire logic          bus_term,
  input  wire logic [1:0]    bus_kind,
  input  wire logic [1:0]    bus_beat,
  input  wire logic [3:0]    eu_need_beat,
  input  wire logic [AW-1:0] bus_addr,
  input  wire logic          prefetch_busy,
  input  wire logic          xlat_valid,
  input  wire logic          xlat_fetch,
  input  wire logic          xlat_write,
  input  wire logic          xlat_super,
  input  wire logic          xlat_hit,
  input  wire logic          xlat_retry,
  input  wire logic          page_wp,
  input  wire logic          page_super_only,
  input  wire logic          page_resident,
  input  wire logic [AW-1:0] xlat_addr,
  input  wire logic          walk_done,
  input  wire logic          walk_invalid,
  input  wire logic          walk_tea,
  input  wire logic          prefetch_req,
  input  wire logic [AW-1:0] prefetch_addr,
  input  wire logic          fetch_used,
  input  wire logic          change_of_flow,
  input  wire logic [AW-1:0] pc_logical,
  input  wire logic          pipe_idle,
  input  wire logic          earlier_done,
  input  wire logic          earlier_exc,
  input  wire logic [15:0]   processor_state_word,
  input  wire logic [2:0]    wb_valid,
  input  wire logic [DW-1:0] wb_data0,
  input  wire logic [DW-1:0] wb_data1,
  input  wire logic [DW-1:0] wb_data2,
  input  wire logic          stack_done,
  input  wire logic          vec_done,
  input  wire logic          exc_addr_err,
  input  wire logic          rte_reload,
  input  wire logic          reset_exc_active,
  output logic               prefetch_issue,
  output logic               line_abort,
  output logic               walk_start,
  output logic               freeze_pipe,
  output logic               cancel_icache,
  output logic               hold_writes,
  output logic               reissue_prefetch,
  output logic [15:0]        next_state_word,
  output logic               stack_req,
  output logic               vec_fetch_req,
  output logic [31:0]        vec_fetch_addr,
  output logic               vec_fetch_super,
  output logic               mem_inhibit,
  output logic [3:0]         processor_status_code
);
  logic                tea_s;
  afae_pkg::afae_state_t state;
  afae_pkg::afae_state_t next_state;
  afae_pkg::afae_cause_t cause;
  logic                cause_ext;
  logic [AW-1:0]       cause_addr;
  logic                pend_fetch;
  logic                pend_fetch_ext;
  logic [AW-1:0]       pend_fetch_addr;
  logic                pend_addr;
  logic [AW-1:0]       pend_addr_val;
  logic                walk_bad;
  logic [31:0]         vbp;
  logic [7:0]          frame_vec;
  logic [AW-1:0]       frame_pc;
  logic [15:0]         frame_sw;
  logic [AW-1:0]       frame_addr;
  logic                frame_ext;
  logic [2:0]          frame_wbv;
  logic [DW-1:0]       frame_wb [3];
  logic                ext_data_fault;
  logic                ext_fetch_fault;
  logic                int_fault;
  logic                data_fault;
  logic                odd_fetch;
  logic                take_fetch;
  logic                double_fault;
  logic                in_exc;

  initial
  begin
    if (AW > 32 || DW > 32 || AW < 2)
    begin
      $error("afae_unit serves address and data widths of 2 to 32 bits");
    end
  end

  afae_sync u_tea_sync
  (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (transfer_error_ack),
    .sync_out (tea_s)
  );

  // External faults are terminations with error acknowledge.  (see [RQ1])
  assign ext_data_fault = tea_s && bus_term &&
                          (bus_kind == afae_pkg::AFAE_KIND_WRITE ||   // see [RQ2]
                           bus_kind == afae_pkg::AFAE_KIND_READ ||    // see [RQ3]
                           (bus_kind == afae_pkg::AFAE_KIND_LINE &&
                            (bus_beat == 2'h0 || eu_need_beat[bus_beat])));  // see [RQ4]
  assign ext_fetch_fault = tea_s && bus_term && bus_kind == afae_pkg::AFAE_KIND_FETCH;
  // Protection faults on a hit, or a failed table search caught at the retry.
  assign int_fault = xlat_valid &&
                     ((xlat_hit && (xlat_write && page_wp || !xlat_super && page_super_only ||
                                    !page_resident)) ||                 // see [RQ8]
                      (xlat_retry && walk_bad));                         // see [RQ9]
  assign data_fault = ext_data_fault || (int_fault && !xlat_fetch);      // see [RQ6]
  assign odd_fetch = prefetch_req && prefetch_addr[0];
  assign take_fetch = pend_fetch && fetch_used;
  assign in_exc = state == afae_pkg::AFAE_SAVE || state == afae_pkg::AFAE_STACK ||
                  state == afae_pkg::AFAE_VECT;
  assign double_fault = ((in_exc || reset_exc_active) && (tea_s && bus_term || exc_addr_err))
                        || (rte_reload && tea_s && bus_term);           // see [RQ17]

  // Table search result is kept until the retried access consumes it.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      walk_bad <= 1'b0;
      walk_start <= 1'b0;
    end
    else
    begin
      walk_start <= xlat_valid && !xlat_hit && !xlat_retry;             // see [RQ9]
      if (walk_done)
      begin
        walk_bad <= walk_invalid || walk_tea;
      end
      else if (xlat_valid && xlat_retry)
      begin
        walk_bad <= 1'b0;
      end
    end
  end

  // Prefetch faults stay pending until used; a new fault wins over a flow change.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pend_fetch <= 1'b0;
      pend_fetch_ext <= 1'b0;
      pend_fetch_addr <= '0;
    end
    else if (ext_fetch_fault || (int_fault && xlat_fetch))
    begin
      pend_fetch <= 1'b1;                                                // see [RQ5]
      pend_fetch_ext <= ext_fetch_fault;
      pend_fetch_addr <= ext_fetch_fault ? bus_addr : xlat_addr;
    end
    else if (change_of_flow || (take_fetch && state == afae_pkg::AFAE_IDLE && !data_fault))
    begin
      pend_fetch <= 1'b0;                                                // see [RQ5]
    end
  end

  // Odd prefetch targets never reach the bus.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      prefetch_issue <= 1'b0;
      pend_addr <= 1'b0;
      pend_addr_val <= '0;
    end
    else
    begin
      prefetch_issue <= prefetch_req && !prefetch_addr[0] && state != afae_pkg::AFAE_HALT;
      if (odd_fetch)
      begin
        pend_addr <= 1'b1;                                               // see [RQ19]
        pend_addr_val <= prefetch_addr;
      end
      else if (state == afae_pkg::AFAE_IDLE && !data_fault && !take_fetch)
      begin
        pend_addr <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      line_abort <= 1'b0;
    end
    else
    begin
      line_abort <= tea_s && bus_term && bus_kind == afae_pkg::AFAE_KIND_LINE;  // see [RQ4]
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      afae_pkg::AFAE_IDLE:
      begin
        if (data_fault || take_fetch || pend_addr)
        begin
          next_state = afae_pkg::AFAE_DRAIN;
        end
      end
      afae_pkg::AFAE_DRAIN:
      begin
        if (earlier_exc)
        begin
          next_state = afae_pkg::AFAE_IDLE;                              // see [RQ11]
        end
        else if (pipe_idle && earlier_done && !prefetch_busy)  // see [RQ13]
        begin
          next_state = afae_pkg::AFAE_SAVE;                              // see [RQ10]
        end
      end
      afae_pkg::AFAE_SAVE:
      begin
        next_state = double_fault ? afae_pkg::AFAE_HALT : afae_pkg::AFAE_STACK;
      end
      afae_pkg::AFAE_STACK:
      begin
        if (double_fault)
        begin
          next_state = afae_pkg::AFAE_HALT;
        end
        else if (stack_done)
        begin
          next_state = afae_pkg::AFAE_VECT;
        end
      end
      afae_pkg::AFAE_VECT:
      begin
        if (double_fault)
        begin
          next_state = afae_pkg::AFAE_HALT;
        end
        else if (vec_done)
        begin
          next_state = afae_pkg::AFAE_IDLE;
        end
      end
      afae_pkg::AFAE_HALT:
      begin
        next_state = afae_pkg::AFAE_HALT;                                // see [RQ18]
      end
      default:
      begin
        next_state = afae_pkg::AFAE_IDLE;
      end
    endcase
    if (state != afae_pkg::AFAE_HALT && double_fault)
    begin
      next_state = afae_pkg::AFAE_HALT;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state <= afae_pkg::AFAE_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Only the highest priority cause is kept; the rest stay pending in pend_fetch and pend_addr.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cause <= afae_pkg::AFAE_CAUSE_DATA;
      cause_ext <= 1'b0;
      cause_addr <= '0;
    end
    else if (state == afae_pkg::AFAE_IDLE)
    begin
      if (data_fault)
      begin
        cause <= afae_pkg::AFAE_CAUSE_DATA;                              // see [RQ10]
        cause_ext <= ext_data_fault;
        cause_addr <= ext_data_fault ? bus_addr : xlat_addr;
      end
      else if (take_fetch)
      begin
        cause <= afae_pkg::AFAE_CAUSE_FETCH;
        cause_ext <= pend_fetch_ext;
        cause_addr <= pend_fetch_addr;
      end
      else if (pend_addr)
      begin
        cause <= afae_pkg::AFAE_CAUSE_ADDR;                              // see [RQ20]
        cause_ext <= 1'b0;
        cause_addr <= {pend_addr_val[AW-1:1], 1'b0};                     // see [RQ22]
      end
    end
  end

  // Pipeline control while an exception is outstanding; the icache is cancelled for a data cause only.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      freeze_pipe <= 1'b0;
      cancel_icache <= 1'b0;
      hold_writes <= 1'b0;
      reissue_prefetch <= 1'b0;
    end
    else
    begin
      freeze_pipe <= next_state != afae_pkg::AFAE_IDLE;                  // see [RQ7]
      cancel_icache <= next_state != afae_pkg::AFAE_IDLE &&
                       (state == afae_pkg::AFAE_IDLE ? data_fault :
                        cause == afae_pkg::AFAE_CAUSE_DATA);             // see [RQ7]
      hold_writes <= next_state != afae_pkg::AFAE_IDLE &&
                     next_state != afae_pkg::AFAE_HALT;                  // see [RQ7]
      reissue_prefetch <= state == afae_pkg::AFAE_DRAIN && earlier_exc &&
                          cause == afae_pkg::AFAE_CAUSE_FETCH;           // see [RQ12]
    end
  end

  // Frame capture once every stage has gone idle.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      frame_vec <= 8'h00;
      frame_pc <= '0;
      frame_sw <= 16'h0000;
      frame_addr <= '0;
      frame_ext <= 1'b0;
      frame_wbv <= 3'h0;
      frame_wb <= '{default: '0};
    end
    else if (state == afae_pkg::AFAE_DRAIN && next_state == afae_pkg::AFAE_SAVE)
    begin
      frame_vec <= cause == afae_pkg::AFAE_CAUSE_ADDR ? `AFAE_VEC_ADDR_ERR :  // see [RQ21]
                   `AFAE_VEC_ACCESS;                                     // see [RQ14]
      frame_pc <= pc_logical;                                            // see [RQ15]
      frame_sw <= processor_state_word;                                  // see [RQ14]
      frame_addr <= cause_addr;
      frame_ext <= cause_ext;                                            // see [RQ6]
      frame_wbv <= wb_valid;                                             // see [RQ16]
      frame_wb <= '{wb_data0, wb_data1, wb_data2};
    end
  end

  // Exception side effects and the vector fetch.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      next_state_word <= 16'h0000;
      stack_req <= 1'b0;
      vec_fetch_req <= 1'b0;
      vec_fetch_addr <= 32'h0000_0000;
      vec_fetch_super <= 1'b0;
      mem_inhibit <= 1'b0;
      processor_status_code <= `AFAE_PST_RUN;
    end
    else
    begin
      if (state == afae_pkg::AFAE_SAVE)
      begin
        next_state_word <= frame_sw;
        next_state_word[`AFAE_SW_SUPER] <= 1'b1;                         // see [RQ14]
        next_state_word[`AFAE_SW_TRACE_HIGH] <= 1'b0;
        next_state_word[`AFAE_SW_TRACE_LOW] <= 1'b0;
        vec_fetch_addr <= vbp + ({24'h000000, frame_vec} << `AFAE_VEC_SCALE);  // see [RQ23]
      end
      stack_req <= next_state == afae_pkg::AFAE_STACK;                   // see [RQ15]
      vec_fetch_req <= next_state == afae_pkg::AFAE_VECT;                // see [RQ24]
      vec_fetch_super <= next_state == afae_pkg::AFAE_VECT;
      mem_inhibit <= next_state == afae_pkg::AFAE_HALT;                  // see [RQ18]
      processor_status_code <= next_state == afae_pkg::AFAE_HALT ? `AFAE_PST_HALT :
                               next_state == afae_pkg::AFAE_IDLE ? `AFAE_PST_RUN :
                               `AFAE_PST_EXC;                            // see [RQ17]
    end
  end

  // Register port: vector base is writable, frame and status are read back.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      vbp <= `AFAE_RST_VBP;
    end
    else if (reg_wr && reg_addr == `AFAE_OFF_VBP)
    begin
      vbp <= {reg_wdata[31:2], 2'b00};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `AFAE_OFF_VBP:        reg_rdata <= vbp;
        `AFAE_OFF_STATUS:     reg_rdata <= {12'h000, frame_wbv, frame_ext, frame_vec,
                                            1'b0, state, processor_status_code};
        `AFAE_OFF_FRAME_PC:   reg_rdata <= 32'(frame_pc);
        `AFAE_OFF_FRAME_SW:   reg_rdata <= {16'h0000, frame_sw};
        `AFAE_OFF_FRAME_ADDR: reg_rdata <= 32'(frame_addr);
        `AFAE_OFF_WB0:        reg_rdata <= 32'(frame_wb[0]);
        `AFAE_OFF_WB1:        reg_rdata <= 32'(frame_wb[1]);
        `AFAE_OFF_WB2:        reg_rdata <= 32'(frame_wb[2]);
        default:              reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_halt_sticky;
    state == afae_pkg::AFAE_HALT |=> state == afae_pkg::AFAE_HALT [*8];
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt left"); // see [RQ18]

  property p_halt_code;
    double_fault && state != afae_pkg::AFAE_HALT |=>
      processor_status_code == `AFAE_PST_HALT && mem_inhibit;
  endproperty
  a_halt_code: assert property (p_halt_code) else $error("no halt code"); // see [RQ17]

  property p_odd_no_fetch;
    odd_fetch |=> !prefetch_issue && pend_addr;
  endproperty
  a_odd_no_fetch: assert property (p_odd_no_fetch) else $error("odd prefetch went out"); // see [RQ19]

  property p_write_fault;
    state == afae_pkg::AFAE_IDLE && tea_s && bus_term &&
      bus_kind == afae_pkg::AFAE_KIND_WRITE && !double_fault |=>
      state == afae_pkg::AFAE_DRAIN && freeze_pipe && cancel_icache;
  endproperty
  a_write_fault: assert property (p_write_fault) else $error("write fault not taken"); // see [RQ2]

  property p_late_beat;
    state == afae_pkg::AFAE_IDLE && tea_s && bus_term && bus_kind == afae_pkg::AFAE_KIND_LINE &&
      bus_beat != 2'h0 && !eu_need_beat[bus_beat] && !pend_fetch && !pend_addr &&
      !int_fault && !double_fault |=> state == afae_pkg::AFAE_IDLE && line_abort;
  endproperty
  a_late_beat: assert property (p_late_beat) else $error("unneeded beat faulted"); // see [RQ4]

  property p_drop;
    state == afae_pkg::AFAE_DRAIN && earlier_exc && !double_fault |=>
      state == afae_pkg::AFAE_IDLE && reissue_prefetch == ($past(cause) ==
      afae_pkg::AFAE_CAUSE_FETCH);
  endproperty
  a_drop: assert property (p_drop) else $error("pending fault not dropped"); // see [RQ11]

  property p_wait_fetch;
    state == afae_pkg::AFAE_DRAIN && prefetch_busy |=> state != afae_pkg::AFAE_SAVE;
  endproperty
  a_wait_fetch: assert property (p_wait_fetch) else $error("prefetch not awaited"); // see [RQ13]

  property p_vec_addr;
    state == afae_pkg::AFAE_SAVE && !double_fault |=>
      vec_fetch_addr == vbp + {22'h000000, frame_vec, 2'b00} &&
      !next_state_word[`AFAE_SW_TRACE_HIGH] && !next_state_word[`AFAE_SW_TRACE_LOW] &&
      next_state_word[`AFAE_SW_SUPER];
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad vector address or state word"); // see [RQ24]

  property p_addr_frame;
    state == afae_pkg::AFAE_SAVE && cause == afae_pkg::AFAE_CAUSE_ADDR |->
      frame_vec == `AFAE_VEC_ADDR_ERR && !frame_addr[0];
  endproperty
  a_addr_frame: assert property (p_addr_frame) else $error("bad address error frame"); // see [RQ22]

  property p_flow_clear;
    change_of_flow && !ext_fetch_fault && !(int_fault && xlat_fetch) |=> !pend_fetch;
  endproperty
  a_flow_clear: assert property (p_flow_clear) else $error("flow change kept fault"); // see [RQ5]

  c_halt: cover property (state == afae_pkg::AFAE_HALT);
  c_addr_err: cover property (state == afae_pkg::AFAE_VECT && frame_vec == `AFAE_VEC_ADDR_ERR);
  c_full: cover property (state == afae_pkg::AFAE_VECT ##1 state == afae_pkg::AFAE_IDLE);
  c_drop: cover property (reissue_prefetch);
endmodule

// File: test/afae_bus_model.sv
// Purpose: External bus logic that ends a bus cycle with a transfer error.
// Assumes: The error pin is asynchronous to the core, so it leads the termination.
// Notes:   lag slows the answer; kind is inverted while no cycle ends.
`timescale 1ns/1ps
module afae_bus_model (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic [3:0] lag,
  output logic            transfer_error_ack,
  output logic            bus_term,
  output logic [1:0]      bus_kind
);
  initial
  begin
    transfer_error_ack = 1'h0;
    bus_term = 1'h0;
    bus_kind = 2'h3;
  end
  always @(posedge mclk)
    if (go)
    begin
      transfer_error_ack <= 1'h1;
      repeat (2 + lag) @(posedge mclk);
      bus_term <= 1'h1;
      bus_kind <= kind;
      @(posedge mclk);
      bus_term <= 1'h0;
      transfer_error_ack <= 1'h0;
      bus_kind <= ~kind;
    end
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench for the exception unit.
// Assumes: Inputs change at rising edges, outputs are read at falling edges.
// Notes:   Pipeline stays idle so faults go straight to stacking unless earlier_exc drops them.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0, stack_done = 1'h0;
  logic vec_done = 1'h0, prefetch_busy = 1'h0, xlat_valid = 1'h0, xlat_fetch = 1'h0;
  logic xlat_write = 1'h0, xlat_super = 1'h0, xlat_hit = 1'h0, xlat_retry = 1'h0, page_wp = 1'h0;
  logic page_super_only = 1'h0, page_resident = 1'h0, walk_done = 1'h0, walk_invalid = 1'h0;
  logic walk_tea = 1'h0, prefetch_req = 1'h0, fetch_used = 1'h0, change_of_flow = 1'h0;
  logic pipe_idle = 1'h1, earlier_done = 1'h1, earlier_exc = 1'h0, exc_addr_err = 1'h0;
  logic rte_reload = 1'h0, reset_exc_active = 1'h0, transfer_error_ack, bus_term, prefetch_issue;
  logic line_abort, walk_start, freeze_pipe, cancel_icache, hold_writes, reissue_prefetch;
  logic stack_req, vec_fetch_req, vec_fetch_super, mem_inhibit;
  logic [1:0] bus_beat = 2'h0, kind = 2'h0, bus_kind;
  logic [2:0] wb_valid = 3'h0;
  logic [3:0] eu_need_beat = 4'h0, lag = 4'h0, processor_status_code;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] processor_state_word = 16'hC000, next_state_word;
  logic [31:0] reg_wdata = 32'h0, bus_addr = 32'h3000, xlat_addr = 32'h0, prefetch_addr = 32'h0;
  logic [31:0] pc_logical = 32'h4444, wb_data0 = 32'h0, wb_data1 = 32'h0, wb_data2 = 32'h0;
  logic [31:0] reg_rdata, vec_fetch_addr, s;
  int bad_count = 0, n_compared = 0, cyc = 0;
  afae_unit dut_u (.*);
  afae_bus_model bm_u (.*);
  initial forever #4 mclk = ~mclk;
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic do_reset();
    @(posedge mclk) nrst <= 1'h0;
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk) reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk) reg_rd <= 1'h0;
    @(negedge mclk) s = reg_rdata;
  endtask
  task automatic fire();
    @(posedge mclk) go <= 1'h1;
    @(posedge mclk) go <= 1'h0;
  endtask
  task automatic pref(input logic [31:0] a, input logic e);
    @(posedge mclk) prefetch_addr <= a;
    prefetch_req <= 1'h1;
    @(posedge mclk) prefetch_req <= 1'h0;
    @(negedge mclk) chk(prefetch_issue, e);
  endtask
  task automatic run_exc(input logic [31:0] va, input logic ci);
    for (int i = 0; i < 30 && stack_req !== 1'h1; i++) @(negedge mclk);
    chk(stack_req, 1'h1);
    chk(next_state_word, 16'h2000);
    chk(processor_status_code, 4'hC);
    chk(vec_fetch_addr, va);
    chk(cancel_icache, ci);
    chk(hold_writes, 1'h1);
    @(posedge mclk) stack_done <= 1'h1;
    @(posedge mclk) stack_done <= 1'h0;
    for (int i = 0; i < 30 && vec_fetch_req !== 1'h1; i++) @(negedge mclk);
    chk(vec_fetch_req, 1'h1);
    chk(vec_fetch_super, 1'h1);
    @(posedge mclk) vec_done <= 1'h1;
    @(posedge mclk) vec_done <= 1'h0;
    repeat (2) @(negedge mclk);
    chk(freeze_pipe, 1'h0);
  endtask
  task automatic line_err();
    @(posedge mclk) kind <= 2'h2;
    bus_beat <= 2'h2;
    fire();
    repeat (4) @(negedge mclk);
    chk(line_abort, 1'h1);
    repeat (2) @(negedge mclk);
    chk(freeze_pipe, 1'h0);
  endtask
  task automatic fetch_case(input logic flow);
    @(posedge mclk) kind <= 2'h3;
    earlier_exc <= !flow;
    fire();
    repeat (4) @(posedge mclk);
    change_of_flow <= flow;
    @(posedge mclk) change_of_flow <= 1'h0;
    fetch_used <= 1'h1;
    @(posedge mclk) fetch_used <= 1'h0;
    repeat (2) @(negedge mclk);
    chk(reissue_prefetch, !flow);
    chk(freeze_pipe, 1'h0);
    @(posedge mclk) kind <= 2'h0;
  endtask
  initial
  begin
    do_reset();
    wr(8'h00, 32'h1003);
    rd(8'h00);
    chk(s, 32'h1000);
    rd(8'h24);
    chk(s, 32'h0);
    fire();
    run_exc(32'h1008, 1'h1);
    rd(8'h10);
    chk(s, 32'h3000);
    rd(8'h08);
    chk(s, 32'h4444);
    rd(8'h04);
    chk(s[16:8], 9'h102);
    pref(32'h2001, 1'h0);
    run_exc(32'h100C, 1'h0);
    rd(8'h10);
    chk(s, 32'h2000);
    pref(32'h2004, 1'h1);
    line_err();
    fetch_case(1'h0);
    fetch_case(1'h1);
    fire();
    for (int i = 0; i < 30 && stack_req !== 1'h1; i++) @(negedge mclk);
    lag <= 4'h3;
    fire();
    repeat (10) @(negedge mclk);
    chk(processor_status_code, 4'h5);
    chk(mem_inhibit, 1'h1);
    chk(stack_req, 1'h0);
    do_reset();
    chk(processor_status_code, 4'h0);
    chk(mem_inhibit, 1'h0);
    end_sim();
  end
endmodule
